/* File: rtl/tbs_pkg.sv */
package tbs_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS        = 8'h00;
    localparam logic [7:0] STATUS_OFS      = 8'h04;
    localparam logic [7:0] CYCLE_US_OFS    = 8'h08;
    localparam logic [7:0] TBL_INDEX_OFS   = 8'h0C;
    localparam logic [7:0] TBL_NUMBER_OFS  = 8'h10;
    localparam logic [7:0] TBL_TASK_OFS    = 8'h14;
    localparam logic [7:0] TBL_ARG_OFS     = 8'h18;
    localparam logic [7:0] TBL_MODE_OFS    = 8'h1C;
    localparam logic [7:0] ALARM_OFS       = 8'h20;
    localparam logic [7:0] DECEL_OFS       = 8'h24;
    localparam logic [7:0] JERK_VALUE_OFS  = 8'h28;

    // Control register bit positions
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_MDI_BIT     = 1;
    localparam int CTRL_START_BIT   = 2;
    localparam int CTRL_START_LO    = 8;

    // Status word bit positions
    localparam int STAT_OUT1_BIT    = 10;
    localparam int STAT_OUT2_BIT    = 11;
    localparam int STAT_FSTOP_BIT   = 14;

    // Task codes
    localparam logic [3:0] TASK_POS     = 4'h1;
    localparam logic [3:0] TASK_FSTOP   = 4'h2;
    localparam logic [3:0] TASK_RUN_FWD = 4'h3;
    localparam logic [3:0] TASK_RUN_REV = 4'h4;
    localparam logic [3:0] TASK_WAIT    = 4'h5;
    localparam logic [3:0] TASK_JUMP    = 4'h6;
    localparam logic [3:0] TASK_OUT_SET = 4'h7;
    localparam logic [3:0] TASK_OUT_CLR = 4'h8;
    localparam logic [3:0] TASK_JERK    = 4'h9;

    // Continuation conditions
    localparam logic [3:0] CONT_END       = 4'h0;
    localparam logic [3:0] CONT_HALT      = 4'h1;
    localparam logic [3:0] CONT_MOTION    = 4'h2;
    localparam logic [3:0] CONT_TRIG      = 4'h3;
    localparam logic [3:0] CONT_HOLD_TRIG = 4'h4;
    localparam logic [3:0] CONT_WARN      = 4'h5;

    // Alarm bits
    localparam int ALM_JUMP_MISSING = 0;
    localparam int ALM_NO_TRIGGER   = 1;
    localparam int ALM_BAD_COND     = 2;

    // Reset values and timing
    localparam logic [15:0] CYCLE_US_RST  = 16'h0FA0;
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          US_NS         = 1000;
    localparam int          US_CYCLES     = US_NS / CLK_PERIOD_NS;
    localparam logic [5:0]  NO_BLOCK      = 6'h3F;

    typedef enum logic [2:0] {
        TBS_IDLE  = 3'b000,
        TBS_FETCH = 3'b001,
        TBS_MOVE  = 3'b011,
        TBS_STOP  = 3'b010,
        TBS_WAIT  = 3'b110,
        TBS_HOLD  = 3'b111,
        TBS_TRIG  = 3'b101
    } tbs_state_type;

endpackage

/* File: rtl/tbs_sequencer.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module tbs_sequencer
    import tbs_pkg::*;
#(
    parameter int NBLK = 64
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axil_awaddr,
    input  wire logic        s_axil_awvalid,
    output logic             s_axil_awready,
    input  wire logic [31:0] s_axil_wdata,
    input  wire logic [3:0]  s_axil_wstrb,
    input  wire logic        s_axil_wvalid,
    output logic             s_axil_wready,
    output logic [1:0]       s_axil_bresp,
    output logic             s_axil_bvalid,
    input  wire logic        s_axil_bready,
    input  wire logic [7:0]  s_axil_araddr,
    input  wire logic        s_axil_arvalid,
    output logic             s_axil_arready,
    output logic [31:0]      s_axil_rdata,
    output logic [1:0]       s_axil_rresp,
    output logic             s_axil_rvalid,
    input  wire logic        s_axil_rready,
    input  wire logic        ipo_tick,
    input  wire logic        hold_request_n,
    input  wire logic        abort_request_n,
    input  wire logic        ext_block_change,
    input  wire logic        at_target,
    input  wire logic        at_standstill,
    input  wire logic        travel_stop,
    input  wire logic        fixed_stop_reached,
    input  wire logic        jerk_limit_enable_input,
    output logic             move_active,
    output logic             move_reverse,
    output logic             move_endless,
    output logic             torque_limited,
    output logic [5:0]       active_block,
    output logic             brake_request,
    output logic             brake_max_decel,
    output logic [15:0]      brake_decel,
    output logic             jerk_limit_on,
    output logic [15:0]      jerk_limit_out,
    output logic             dynamic_lag_monitor,
    output logic [15:0]      motion_status_word
);

    tbs_state_type state_q;
    logic [31:0] ctrl_q, cycle_q, index_q, alarm_q, decel_q, jerk_q;
    logic [7:0]  num_mem  [NBLK];  // block_number, 8'hFF unused
    logic [3:0]  task_mem [NBLK];
    logic [31:0] arg_mem  [NBLK];  // task_argument
    logic [15:0] mode_mem [NBLK];  // task_mode_word
    logic [5:0]  slot_q;
    logic [31:0] wait_q;
    logic        out1_q, out2_q, fstop_q, trig_q, jerk_on_q;
    logic [NBLK-1:0] bad_blk_q;

    // Sync of pin inputs
    logic [1:0] hold_s, abort_s, ext_s, ext_d;
    always_ff @(posedge aclk)
    begin
        hold_s  <= {hold_s[0], hold_request_n};
        abort_s <= {abort_s[0], abort_request_n};
        ext_s   <= {ext_s[0], ext_block_change};
        ext_d   <= {ext_d[0], ext_s[1]};
    end
    wire ext_rise = ext_s[1] & ~ext_d[0];
    wire modes_ok = ctrl_q[CTRL_ENABLE_BIT] | ctrl_q[CTRL_MDI_BIT];
    wire hold_act  = modes_ok & ~hold_s[1];
    wire abort_act = modes_ok & ~abort_s[1];

    // AXI4-Lite write channel
    logic aw_hold, w_hold;
    logic [7:0] aw_a;
    logic [31:0] w_d;
    assign s_axil_awready = ~aw_hold & ~s_axil_bvalid;
    assign s_axil_wready  = ~w_hold & ~s_axil_bvalid;
    assign s_axil_bresp   = 2'h0;
    wire do_wr = aw_hold & w_hold & ~s_axil_bvalid;
    wire start_pulse = do_wr & (aw_a == CTRL_OFS) & w_d[CTRL_START_BIT];
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axil_bvalid <= 1'b0;
            aw_a <= 8'h00;
            w_d <= 32'h0;
        end
        else
        begin
            if (s_axil_awvalid && s_axil_awready)
            begin
                aw_hold <= 1'b1;
                aw_a <= s_axil_awaddr;
            end
            if (s_axil_wvalid && s_axil_wready)
            begin
                w_hold <= 1'b1;
                w_d <= s_axil_wdata;
            end
            if (do_wr)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axil_bvalid <= 1'b1;
            end
            else if (s_axil_bready)
                s_axil_bvalid <= 1'b0;
        end
    end

    // Register stores
    wire [5:0] idx = index_q[5:0];
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= 32'h0;
            cycle_q <= {16'h0, CYCLE_US_RST};
            index_q <= 32'h0;
            decel_q <= 32'h0;
            jerk_q <= 32'h0;
        end
        else if (do_wr)
        begin
            if (aw_a == CTRL_OFS)
                ctrl_q <= w_d & 32'h0000_3F03;
            else if (aw_a == CYCLE_US_OFS)
                cycle_q <= w_d;
            else if (aw_a == TBL_INDEX_OFS)
                index_q <= w_d & 32'h3F;
            else if (aw_a == DECEL_OFS)
                decel_q <= w_d;
            else if (aw_a == JERK_VALUE_OFS)
                jerk_q <= w_d;
        end
    end

    // Block table
    always_ff @(posedge aclk)
    begin
        if (do_wr)
        begin
            if (aw_a == TBL_NUMBER_OFS)
                num_mem[idx] <= w_d[7:0];
            else if (aw_a == TBL_TASK_OFS)
                task_mem[idx] <= w_d[3:0];
            else if (aw_a == TBL_ARG_OFS)
                arg_mem[idx] <= w_d;
            else if (aw_a == TBL_MODE_OFS)
                mode_mem[idx] <= w_d[15:0];
        end
    end

    // Read channel
    assign s_axil_arready = ~s_axil_rvalid;
    assign s_axil_rresp = 2'h0;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0;
        end
        else if (s_axil_arvalid && s_axil_arready)
        begin
            s_axil_rvalid <= 1'b1;
            if (s_axil_araddr == CTRL_OFS)
                s_axil_rdata <= ctrl_q;
            else if (s_axil_araddr == STATUS_OFS)
                s_axil_rdata <= {13'h0, state_q, motion_status_word};
            else if (s_axil_araddr == CYCLE_US_OFS)
                s_axil_rdata <= cycle_q;
            else if (s_axil_araddr == TBL_INDEX_OFS)
                s_axil_rdata <= index_q;
            else if (s_axil_araddr == TBL_NUMBER_OFS)
                s_axil_rdata <= {24'h0, num_mem[idx]};
            else if (s_axil_araddr == TBL_TASK_OFS)
                s_axil_rdata <= {27'h0, bad_blk_q[idx], task_mem[idx]};
            else if (s_axil_araddr == TBL_ARG_OFS)
                s_axil_rdata <= arg_mem[idx];
            else if (s_axil_araddr == TBL_MODE_OFS)
                s_axil_rdata <= {16'h0, mode_mem[idx]};
            else if (s_axil_araddr == ALARM_OFS)
                s_axil_rdata <= alarm_q;
            else if (s_axil_araddr == DECEL_OFS)
                s_axil_rdata <= decel_q;
            else if (s_axil_araddr == JERK_VALUE_OFS)
                s_axil_rdata <= jerk_q;
            else
                s_axil_rdata <= 32'h0;
        end
        else if (s_axil_rready)
            s_axil_rvalid <= 1'b0;
    end

    // Current block decode
    wire [3:0] cur_task = task_mem[slot_q];
    wire [3:0] cur_cond = mode_mem[slot_q][7:4];
    wire [31:0] cur_arg = arg_mem[slot_q];

    // Slot lookup by block number and next slot in number order
    logic [5:0] jump_slot, next_slot;
    logic       jump_found, next_found;
    always_comb
    begin
        jump_slot = 6'h0;
        jump_found = 1'b0;
        next_slot = 6'h0;
        next_found = 1'b0;
        for (int i = 0; i < NBLK; i++)
        begin
            if (!jump_found && num_mem[i] == cur_arg[7:0] && num_mem[i] != 8'hFF)
            begin
                jump_found = 1'b1;
                jump_slot = 6'(i);
            end
            if (num_mem[i] != 8'hFF && num_mem[i] > num_mem[slot_q]
                && (!next_found || num_mem[i] < num_mem[next_slot]))
            begin
                next_found = 1'b1;
                next_slot = 6'(i);
            end
        end
    end

    // Condition legality per task
    logic cond_ok;
    always_comb
    begin
        case (cur_task)
            TASK_FSTOP:   cond_ok = cur_cond inside {CONT_END, CONT_HALT, CONT_TRIG, CONT_HOLD_TRIG};
            TASK_WAIT:    cond_ok = cur_cond inside {CONT_END, CONT_HALT, CONT_TRIG, CONT_HOLD_TRIG,
                                                      CONT_WARN};
            TASK_JUMP:    cond_ok = 1'b1;
            TASK_OUT_SET, TASK_OUT_CLR:
                          cond_ok = cur_cond inside {CONT_END, CONT_MOTION, CONT_HALT, CONT_HOLD_TRIG};
            default:      cond_ok = 1'b1;
        endcase
    end

    // Wait length: ms to cycles rounded up, min one
    wire [31:0] cyc_ms = (cycle_q == 32'h0) ? 32'h1 : cycle_q;
    wire [41:0] wait_us = 42'(cur_arg) * 42'd1000;
    wire [31:0] wait_cycles_raw = 32'((wait_us + 42'(cyc_ms) - 42'd1) / 42'(cyc_ms));
    wire [31:0] wait_cycles = (wait_cycles_raw == 32'h0) ? 32'h1 : wait_cycles_raw;

    // Sequencer
    logic [1:0] quick_q;  // instant tasks done in this cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= TBS_IDLE;
            slot_q <= 6'h0;
            wait_q <= 32'h0;
            out1_q <= 1'b0;
            out2_q <= 1'b0;
            fstop_q <= 1'b0;
            trig_q <= 1'b0;
            jerk_on_q <= 1'b0;
            alarm_q <= 32'h0;
            bad_blk_q <= '0;
            quick_q <= 2'h0;
        end
        else
        begin
            if (do_wr && aw_a == ALARM_OFS)
                alarm_q <= alarm_q & ~w_d;
            if (ext_rise)
                trig_q <= 1'b1;
            if (ipo_tick)
                quick_q <= 2'h0;
            if (abort_act && state_q != TBS_IDLE)
            begin
                state_q <= TBS_IDLE;
                fstop_q <= fstop_q & fixed_stop_reached;
            end
            else
            case (state_q)
                TBS_IDLE:
                    if (start_pulse)
                    begin
                        slot_q <= w_d[CTRL_START_LO +: 6];
                        trig_q <= ext_rise;  // A fresh trigger edge wins over the clear
                        state_q <= TBS_FETCH;
                    end
                TBS_FETCH:
                    if (!cond_ok)
                    begin
                        alarm_q[ALM_BAD_COND] <= 1'b1;
                        state_q <= TBS_IDLE;
                    end
                    else if (cur_task == TASK_JUMP || cur_task == TASK_OUT_SET || cur_task == TASK_OUT_CLR)
                    begin
                        if (quick_q != 2'h2 || ipo_tick)
                        begin
                            quick_q <= ipo_tick ? 2'h1 : quick_q + 2'h1;
                            if (cur_task == TASK_JUMP)
                            begin
                                if (jump_found)
                                    slot_q <= jump_slot;
                                else
                                begin
                                    alarm_q[ALM_JUMP_MISSING] <= 1'b1;
                                    bad_blk_q[slot_q] <= 1'b1;
                                    state_q <= TBS_IDLE;
                                end
                            end
                            else
                            begin
                                // Bit-coded output selection
                                if (cur_arg[0]) out1_q <= (cur_task == TASK_OUT_SET);
                                if (cur_arg[1]) out2_q <= (cur_task == TASK_OUT_SET);
                                state_q <= TBS_STOP;
                            end
                        end
                    end
                    else if (cur_task == TASK_WAIT || cur_task == TASK_JERK)
                    begin
                        if (at_standstill)
                        begin
                            if (cur_task == TASK_JERK)
                            begin
                                jerk_on_q <= cur_arg[0] & ~jerk_limit_enable_input;
                                state_q <= TBS_STOP;
                            end
                            else
                            begin
                                wait_q <= wait_cycles;
                                trig_q <= ext_rise;
                                state_q <= TBS_WAIT;
                            end
                        end
                    end
                    else
                    begin
                        fstop_q <= (cur_task == TASK_FSTOP);
                        trig_q <= ext_rise;
                        state_q <= TBS_MOVE;
                    end
                TBS_MOVE:
                    if (hold_act)
                        state_q <= TBS_HOLD;
                    else if ((cur_task == TASK_RUN_FWD || cur_task == TASK_RUN_REV)
                             && (travel_stop || (trig_q && cur_cond >= CONT_TRIG)))
                        state_q <= travel_stop ? TBS_IDLE : TBS_STOP;
                    else if (cur_task == TASK_FSTOP ? fixed_stop_reached : at_target)
                        state_q <= TBS_STOP;
                TBS_HOLD:
                    if (!hold_act)
                        state_q <= TBS_MOVE;
                TBS_WAIT:
                    if (trig_q)
                        state_q <= TBS_STOP;
                    else if (ipo_tick)
                    begin
                        if (wait_q <= 32'h1)
                        begin
                            if (cur_cond == CONT_WARN)
                                alarm_q[ALM_NO_TRIGGER] <= 1'b1;
                            state_q <= (cur_cond == CONT_WARN) ? TBS_TRIG : TBS_STOP;
                        end
                        wait_q <= wait_q - 32'h1;
                    end
                TBS_STOP:
                    // Continuation decides the advance
                    if (cur_task == TASK_JUMP)
                        state_q <= TBS_FETCH;
                    else if (cur_cond == CONT_END || !next_found)
                        state_q <= TBS_IDLE;
                    else if (cur_cond == CONT_MOTION || cur_cond == CONT_TRIG)
                    begin
                        slot_q <= next_slot;
                        state_q <= TBS_FETCH;
                    end
                    else if (cur_cond == CONT_HALT)
                    begin
                        if (ipo_tick && at_standstill)
                        begin
                            slot_q <= next_slot;
                            state_q <= TBS_FETCH;
                        end
                    end
                    else
                    begin
                        if (cur_cond == CONT_WARN && !trig_q)
                            alarm_q[ALM_NO_TRIGGER] <= 1'b1;
                        state_q <= TBS_TRIG;
                    end
                TBS_TRIG:
                    if (trig_q)
                    begin
                        slot_q <= next_slot;
                        trig_q <= ext_rise;
                        state_q <= TBS_FETCH;
                    end
                default:
                    state_q <= TBS_IDLE;
            endcase
        end
    end
    // Motion command outputs
    always_comb
    begin
        move_active = (state_q == TBS_MOVE);
        move_reverse = move_active && (cur_task == TASK_RUN_REV);
        move_endless = move_active && ((cur_task == TASK_RUN_FWD) || (cur_task == TASK_RUN_REV));
        torque_limited = fstop_q;
        active_block = num_mem[slot_q][5:0];
        brake_request = (state_q == TBS_HOLD) || abort_act;
        brake_max_decel = abort_act;
        brake_decel = abort_act ? jerk_q[31:16] :
                      (ctrl_q[CTRL_MDI_BIT] ? decel_q[15:0] : decel_q[31:16]);
        jerk_limit_on = jerk_on_q;
        jerk_limit_out = jerk_q[15:0];
        dynamic_lag_monitor = ~fstop_q;
        motion_status_word = 16'h0;
        motion_status_word[STAT_OUT1_BIT] = out1_q;
        motion_status_word[STAT_OUT2_BIT] = out2_q;
        motion_status_word[STAT_FSTOP_BIT] = fstop_q;
    end

endmodule // tbs_sequencer

/* File: dv/tbs_sequencer_assertions.sv */
`timescale 1ns/1ps
module tbs_sequencer_chk
    import tbs_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axil_awvalid,
    input wire logic        s_axil_awready,
    input wire logic        s_axil_wvalid,
    input wire logic        s_axil_wready,
    input wire logic        s_axil_bvalid,
    input wire logic        s_axil_bready,
    input wire logic        s_axil_arvalid,
    input wire logic        s_axil_arready,
    input wire logic        s_axil_rvalid,
    input wire logic        s_axil_rready,
    input wire logic        move_active,
    input wire logic        move_endless,
    input wire logic        brake_request,
    input wire logic        dynamic_lag_monitor,
    input wire logic [15:0] motion_status_word
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Lag monitor is off exactly while the fixed stop is active
    lag_vs_fstop_a: assert property (dynamic_lag_monitor != motion_status_word[STAT_FSTOP_BIT])
        else $error("lag monitor and fixed stop bit disagree");
    reset_idle_a: assert property ($rose(aresetn) |-> !move_active && !brake_request && motion_status_word == 16'h0)
        else $error("outputs not idle after reset");
    endless_moves_a: assert property (move_endless |-> move_active)
        else $error("endless run without motion");
    wr_answer_a: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |-> ##[1:2] s_axil_bvalid)
        else $error("write response missing");
    rd_answer_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
        else $error("read data late");
    b_done_a: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
        else $error("write response repeated");
    r_done_a: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
        else $error("read data repeated");
    ar_stall_a: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("read address taken during read data");
    // Main scenarios seen
    cover property (motion_status_word[STAT_FSTOP_BIT]);
    cover property (brake_request && move_active);
    cover property (motion_status_word[STAT_OUT2_BIT:STAT_OUT1_BIT] == 2'h3);
endmodule // tbs_sequencer_chk

bind tbs_sequencer tbs_sequencer_chk tbs_sequencer_chk_i (.aclk, .aresetn, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wvalid, .s_axil_wready, .s_axil_bvalid, .s_axil_bready, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rvalid, .s_axil_rready, .move_active, .move_endless, .brake_request, .dynamic_lag_monitor,
    .motion_status_word);

/* File: dv/tbs_ctrl_model.sv */
`timescale 1ns/1ps
module tbs_ctrl_model #(
    parameter int IPO   = 20,
    parameter int REACH = 3
)(
    input  wire logic aclk,
    input  wire logic hold_cmd,
    input  wire logic abort_cmd,
    input  wire logic trig_cmd,
    input  wire logic move_active,
    output logic      ipo_tick,
    output logic      hold_request_n,
    output logic      abort_request_n,
    output logic      ext_block_change,
    output logic      reached,
    output logic      at_standstill
);
    int tick_q;
    int run_q;
    // Interpolation tick, and ticks spent in the current move
    always_ff @(posedge aclk)
    begin
        tick_q        <= (tick_q == IPO - 1) ? 0 : tick_q + 1;
        ipo_tick      <= tick_q == 0;
        run_q         <= move_active ? run_q + int'(ipo_tick) : 0;
        at_standstill <= !move_active;
    end
    // Target or fixed stop comes REACH ticks into a move
    assign reached = run_q >= REACH;
    // Stop requests active low block change on a rising edge
    assign hold_request_n   = !hold_cmd;
    assign abort_request_n  = !abort_cmd;
    assign ext_block_change = trig_cmd;
endmodule // tbs_ctrl_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
    import tbs_pkg::*;
    logic        aclk = 1'h0, aresetn = 1'h0, hold_cmd = 1'h0, abort_cmd = 1'h0, trig_cmd = 1'h0;
    logic        s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
    logic        s_axil_arvalid = 1'h0, s_axil_rready = 1'h0;
    logic [7:0]  s_axil_awaddr = 8'h0, s_axil_araddr = 8'h0;
    logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, d;
    logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, ipo_tick;
    logic        hold_request_n, abort_request_n, ext_block_change, reached, at_standstill, move_active;
    logic        torque_limited, brake_request, brake_max_decel, dynamic_lag_monitor;
    logic [15:0] motion_status_word;
    int          bad_count = 0, checked = 0, cyc = 0;
    tbs_sequencer tbs_sequencer_i (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
        .s_axil_wstrb(4'hF), .s_axil_wvalid, .s_axil_wready, .s_axil_bresp(), .s_axil_bvalid, .s_axil_bready,
        .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp(), .s_axil_rvalid,
        .s_axil_rready, .ipo_tick, .hold_request_n, .abort_request_n, .ext_block_change, .at_target(reached),
        .at_standstill, .travel_stop(1'h0), .fixed_stop_reached(reached), .jerk_limit_enable_input(1'h0),
        .move_active, .move_reverse(), .move_endless(), .torque_limited, .active_block(), .brake_request,
        .brake_max_decel, .brake_decel(), .jerk_limit_on(), .jerk_limit_out(), .dynamic_lag_monitor,
        .motion_status_word);
    tbs_ctrl_model tbs_ctrl_model_i (.aclk, .hold_cmd, .abort_cmd, .trig_cmd, .move_active, .ipo_tick,
        .hold_request_n, .abort_request_n, .ext_block_change, .reached, .at_standstill);
    // Clock and hang limit
    always #50 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            bad_count = bad_count + 1;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        {s_axil_awaddr, s_axil_wdata} <= {a, v};
        {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'h0;
            if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'h0;
        end while (!s_axil_bvalid);
        s_axil_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axil_araddr <= a;
        {s_axil_arvalid, s_axil_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'h0;
        end while (!s_axil_rvalid);
        d = s_axil_rdata;
        s_axil_rready <= 1'h0;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge ipo_tick);
        @(posedge aclk);
    endtask
    // Load slot s as block number s and start it with the given mode bits
    task automatic blk(input logic [5:0] s, input logic [3:0] t, input logic [15:0] a, input logic [3:0] c,
                       input logic [1:0] m);
        wr(TBL_INDEX_OFS, {26'h0, s});
        wr(TBL_NUMBER_OFS, {26'h0, s});
        wr(TBL_TASK_OFS, {28'h0, t});
        wr(TBL_ARG_OFS, {16'h0, a});
        wr(TBL_MODE_OFS, {24'h0, c, 4'h0});
        wr(CTRL_OFS, {18'h0, s, 5'h0, 1'h1, m});
    endtask
    task automatic t_regs();
        rd(CYCLE_US_OFS);
        chk(d, {16'h0, CYCLE_US_RST});
        rd(8'h3C);
        chk(d, 32'h0);
        $display("registers done");
    endtask
    task automatic t_out();
        for (int k = 1; k < 4; k++)
        begin
            blk(6'h0, TASK_OUT_SET, 16'h3, CONT_END, 2'h1);
            tk(2);
            blk(6'h0, TASK_OUT_CLR, 16'(k), CONT_END, 2'h1);
            tk(2);
            chk({30'h0, motion_status_word[STAT_OUT2_BIT:STAT_OUT1_BIT]}, 32'(3 - k));
        end
        $display("outputs done");
    endtask
    task automatic t_jump();
        blk(6'h1, TASK_JUMP, 16'h32, CONT_END, 2'h1);
        tk(2);
        rd(ALARM_OFS);
        chk(d & 32'h1, 32'h1);
        wr(TBL_INDEX_OFS, 32'h1);
        rd(TBL_TASK_OFS);
        chk(d & 32'h10, 32'h10);
        wr(ALARM_OFS, 32'h7);
        $display("jump done");
    endtask
    task automatic t_hold();
        blk(6'h4, TASK_RUN_FWD, 16'h0, CONT_END, 2'h0);
        tk(1);
        chk({31'h0, move_active}, 32'h1);
        hold_cmd <= 1'h1;
        tk(1);
        chk({31'h0, brake_request}, 32'h0);
        wr(CTRL_OFS, 32'h1);
        tk(1);
        chk({30'h0, brake_request, brake_max_decel}, 32'h2);
        hold_cmd <= 1'h0;
        abort_cmd <= 1'h1;
        tk(1);
        chk({31'h0, brake_max_decel}, 32'h1);
        abort_cmd <= 1'h0;
        tk(2);
        $display("hold and abort done");
    endtask
    task automatic t_wait();
        blk(6'h2, TASK_WAIT, 16'h9, CONT_WARN, 2'h1);
        tk(2);
        rd(ALARM_OFS);
        chk(d & 32'h2, 32'h0);
        tk(3);
        rd(ALARM_OFS);
        chk(d & 32'h2, 32'h2);
        abort_cmd <= 1'h1;
        tk(1);
        abort_cmd <= 1'h0;
        wr(ALARM_OFS, 32'h7);
        blk(6'h2, TASK_WAIT, 16'h28, CONT_END, 2'h1);
        tk(2);
        trig_cmd <= 1'h1;
        tk(1);
        trig_cmd <= 1'h0;
        rd(STATUS_OFS);
        chk({29'h0, d[18:16]}, {29'h0, TBS_IDLE});
        $display("wait done");
    endtask
    task automatic t_fstop();
        blk(6'h3, TASK_FSTOP, 16'h64, CONT_HOLD_TRIG, 2'h1);
        tk(1);
        chk({29'h0, torque_limited, motion_status_word[STAT_FSTOP_BIT], dynamic_lag_monitor}, 32'h6);
        $display("fixed stop done");
    endtask
    task automatic stop_test();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reset, then the scenarios
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_out();
        t_jump();
        t_hold();
        t_wait();
        t_fstop();
        stop_test();
    end
endmodule // tb
